//--- cpf_pkg.sv
// What this block does
// - audio tx service flag at four or fewer
// - audio tx service interrupts unless mask cleared
// - audio tx service drives dma, mask ignored
// - audio rx service flag at four or more
// - audio rx dma unmasked, interrupt only when enabled
// - tel tx service flag at four or fewer
// - tel tx dma unmasked, interrupt gated by mask
// - tel rx service flag at four or more
// - tel rx dma unmasked, interrupt gated by mask
// - audio fetch from empty sets sticky underrun
// - audio underrun repeats last sent sample
// - new data at head resumes transmission
// - audio rx into full drops, sets overrun
// - tel underrun sets sticky, repeats last sample
// - tel rx into full drops, sets overrun
// - audio tx not-full flag, no interrupt
// - audio rx not-empty flag, no interrupt
// - tel tx not-full flag, no interrupt
// - write one clears sticky, flags ignore writes
// - interrupt stands while its bit stays set
// - service flags read zero while port disabled
// - tel rx not-empty flag, no interrupt
package cpf_pkg;
  localparam int unsigned CPF_DW = 16;
  localparam int unsigned CPF_DEPTH = 8;
  localparam int unsigned CPF_NCH = 4;
  localparam int unsigned CPF_AW = 8;

  // channel order: audio tx, audio rx, tel tx, tel rx
  localparam int unsigned CPF_CH_ATX = 0;
  localparam int unsigned CPF_CH_ARX = 1;
  localparam int unsigned CPF_CH_TTX = 2;
  localparam int unsigned CPF_CH_TRX = 3;

  localparam logic [CPF_AW-1:0] CPF_OFS_CTRL = 8'h00;
  localparam logic [CPF_AW-1:0] CPF_OFS_DATA_AUDIO = 8'h04;
  localparam logic [CPF_AW-1:0] CPF_OFS_DATA_TEL = 8'h08;
  localparam logic [CPF_AW-1:0] CPF_OFS_STATUS = 8'h0C;

  localparam int unsigned CPF_CTRL_EN = 0;
  localparam int unsigned CPF_CTRL_MASK = 1;
  localparam int unsigned CPF_ST_SERV = 0;
  localparam int unsigned CPF_ST_ERR = 4;
  localparam int unsigned CPF_ST_LVL = 8;

  localparam logic CPF_EN_RST = 1'b0;
  localparam logic [CPF_NCH-1:0] CPF_MASK_RST = 4'h0;
  // tx not-full reads high and rx not-empty low out of reset
  localparam logic [CPF_NCH-1:0] CPF_LVL_RST = 4'h5;
  localparam logic [31:0] CPF_RD_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [CPF_AW-1:0] paddr;
    logic [31:0] pwdata;
  } cpf_apb_req_t;

  typedef struct packed {
    logic [CPF_NCH-1:0] dma;
    logic [CPF_NCH-1:0] irq_service;
    logic [CPF_NCH-1:0] irq_error;
  } cpf_req_t;
endpackage : cpf_pkg

//--- cpf_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
module cpf_status_flags
  import cpf_pkg::*;
#(
  parameter int unsigned DW = CPF_DW,
  parameter int unsigned DEPTH = CPF_DEPTH
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire cpf_apb_req_t i_apb,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  input wire logic i_audio_tx_fetch,
  output logic [DW-1:0] o_audio_tx_sample,
  input wire logic i_tel_tx_fetch,
  output logic [DW-1:0] o_tel_tx_sample,
  input wire logic i_audio_rx_valid,
  input wire logic [DW-1:0] i_audio_rx_data,
  input wire logic i_tel_rx_valid,
  input wire logic [DW-1:0] i_tel_rx_data,
  output cpf_req_t o_req
);
  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = PW + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  // bus phase decode
  logic pready_q, pready_d;
  logic [31:0] prdata_q, prdata_d;
  logic pslverr_q, pslverr_d;
  logic bus_req, bus_acc, bus_rd_phase, wr_acc, rd_acc;
  logic hit_ctrl, hit_stat, mapped;
  logic [1:0] hit_data;

  assign bus_req = i_apb.psel & i_apb.penable;
  assign bus_acc = bus_req & pready_q;
  assign bus_rd_phase = bus_req & ~pready_q;
  assign wr_acc = bus_acc & i_apb.pwrite;
  assign rd_acc = bus_acc & ~i_apb.pwrite;
  assign hit_ctrl = i_apb.paddr == CPF_OFS_CTRL;
  assign hit_stat = i_apb.paddr == CPF_OFS_STATUS;
  assign hit_data[0] = i_apb.paddr == CPF_OFS_DATA_AUDIO;
  assign hit_data[1] = i_apb.paddr == CPF_OFS_DATA_TEL;
  assign mapped = hit_ctrl | hit_stat | (|hit_data);

  // link side, indexed by pair: 0 audio, 1 tel
  logic [1:0] fetch, rx_valid;
  logic [1:0][DW-1:0] rx_data, tx_sample;
  assign fetch = {i_tel_tx_fetch, i_audio_tx_fetch};
  assign rx_valid = {i_tel_rx_valid, i_audio_rx_valid};
  assign rx_data = {i_tel_rx_data, i_audio_rx_data};

  // per-channel results
  logic [CPF_NCH-1:0] full, empty, set_err, serv_nx, lvl_nx;
  logic [CPF_NCH-1:0][DW-1:0] head;

  // control register
  logic en_q, en_d;
  logic [CPF_NCH-1:0] mask_q, mask_d;

  always_comb begin
    en_d = en_q;
    mask_d = mask_q;
    if (wr_acc && hit_ctrl) begin
      en_d = i_apb.pwdata[CPF_CTRL_EN];
      mask_d = i_apb.pwdata[CPF_CTRL_MASK +: CPF_NCH];
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_q <= CPF_EN_RST;
      mask_q <= CPF_MASK_RST;
    end else begin
      en_q <= en_d;
      mask_q <= mask_d;
    end
  end

  // channel fifos, eight entries each by default
  for (genvar i = 0; i < CPF_NCH; i++) begin : g_ch
    localparam int unsigned P = i / 2;
    logic [DW-1:0] mem_q [DEPTH];
    logic [DW-1:0] mem_d [DEPTH];
    logic [PW-1:0] rd_q, rd_d, wr_q, wr_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic push, pop;
    logic [DW-1:0] wdat;

    if ((i % 2) == 0) begin : g_tx
      logic [DW-1:0] smp_q, smp_d;
      // writes into a full transmit fifo are dropped
      assign push = wr_acc & hit_data[P] & ~full[i];
      assign pop = fetch[P] & ~empty[i];
      assign wdat = i_apb.pwdata[DW-1:0];
      assign set_err[i] = fetch[P] & empty[i];
      assign serv_nx[i] = en_d & (cnt_d <= HALF_CNT);
      assign lvl_nx[i] = cnt_d != FULL_CNT;
      // the sample only moves on a fetch that finds data
      assign smp_d = pop ? head[i] : smp_q;
      assign tx_sample[P] = smp_q;

      always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
        if (!i_arst_n) begin
          smp_q <= '0;
        end else begin
          smp_q <= smp_d;
        end
      end
    end else begin : g_rx
      // samples reaching a full receive fifo are discarded
      assign push = rx_valid[P] & ~full[i];
      assign pop = rd_acc & hit_data[P] & ~empty[i];
      assign wdat = rx_data[P];
      assign set_err[i] = rx_valid[P] & full[i];
      assign serv_nx[i] = en_d & (cnt_d >= HALF_CNT);
      assign lvl_nx[i] = cnt_d != '0;
    end

    assign full[i] = cnt_q == FULL_CNT;
    assign empty[i] = cnt_q == '0;
    assign head[i] = mem_q[rd_q];

    always_comb begin
      mem_d = mem_q;
      rd_d = rd_q;
      wr_d = wr_q;
      if (push) begin
        mem_d[wr_q] = wdat;
        wr_d = (wr_q == LAST_PTR) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_d = (rd_q == LAST_PTR) ? '0 : rd_q + 1'b1;
      end
      case ({push, pop})
        2'b10: cnt_d = cnt_q + 1'b1;
        2'b01: cnt_d = cnt_q - 1'b1;
        default: cnt_d = cnt_q;
      endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
        mem_q <= '{default: '0};
        rd_q <= '0;
        wr_q <= '0;
        cnt_q <= '0;
      end else begin
        mem_q <= mem_d;
        rd_q <= rd_d;
        wr_q <= wr_d;
        cnt_q <= cnt_d;
      end
    end
  end

  // status flags and request outputs
  logic [CPF_NCH-1:0] err_q, err_d, err_clr;
  logic [CPF_NCH-1:0] serv_q, lvl_q;
  cpf_req_t req_q, req_d;

  assign err_clr = (wr_acc && hit_stat) ? i_apb.pwdata[CPF_ST_ERR +: CPF_NCH] : '0;

  always_comb begin
    // a new event in the clearing cycle keeps the bit set
    err_d = (err_q & ~err_clr) | set_err;
    req_d.dma = serv_nx;
    req_d.irq_service = serv_nx & mask_d;
    req_d.irq_error = err_d;
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      err_q <= '0;
      serv_q <= '0;
      lvl_q <= CPF_LVL_RST;
      req_q <= '0;
    end else begin
      err_q <= err_d;
      serv_q <= serv_nx;
      lvl_q <= lvl_nx;
      req_q <= req_d;
    end
  end

  // apb slave: one wait state, read data captured before the pop
  always_comb begin
    pready_d = bus_rd_phase;
    pslverr_d = bus_rd_phase & ~mapped;
    prdata_d = prdata_q;
    if (bus_rd_phase) begin
      prdata_d = CPF_RD_ZERO;
      if (hit_ctrl) begin
        prdata_d[CPF_CTRL_EN] = en_q;
        prdata_d[CPF_CTRL_MASK +: CPF_NCH] = mask_q;
      end else if (hit_stat) begin
        prdata_d[CPF_ST_SERV +: CPF_NCH] = serv_q;
        prdata_d[CPF_ST_ERR +: CPF_NCH] = err_q;
        prdata_d[CPF_ST_LVL +: CPF_NCH] = lvl_q;
      end else if (hit_data[0] && !empty[CPF_CH_ARX]) begin
        prdata_d[DW-1:0] = head[CPF_CH_ARX];
      end else if (hit_data[1] && !empty[CPF_CH_TRX]) begin
        prdata_d[DW-1:0] = head[CPF_CH_TRX];
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= CPF_RD_ZERO;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign o_pready = pready_q;
  assign o_prdata = prdata_q;
  assign o_pslverr = pslverr_q;
  assign o_req = req_q;
  assign o_audio_tx_sample = tx_sample[0];
  assign o_tel_tx_sample = tx_sample[1];
endmodule : cpf_status_flags
`default_nettype wire

//--- cpf_status_flags_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cpf_chk
  import cpf_pkg::*;
#(
  parameter int unsigned DW = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire cpf_apb_req_t i_apb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_audio_tx_fetch,
  input wire logic [DW-1:0] o_audio_tx_sample,
  input wire logic i_tel_tx_fetch,
  input wire logic [DW-1:0] o_tel_tx_sample,
  input wire logic i_audio_rx_valid,
  input wire logic i_tel_rx_valid,
  input wire cpf_req_t o_req
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  apb_answer_a:
    assert property (i_apb.psel && i_apb.penable && !o_pready |=> o_pready) else $error("late");
  ready_pulse_a:
    assert property (o_pready |=> !o_pready) else $error("ready held");
  err_with_ready_a:
    assert property (o_pslverr |-> o_pready) else $error("stray slverr");
  irq_gate_a:
    assert property ((o_req.irq_service & ~o_req.dma) == 4'h0) else $error("irq no service");
  audio_hold_a:
    assert property (!i_audio_tx_fetch |=> $stable(o_audio_tx_sample)) else $error("audio moved");
  tel_hold_a:
    assert property (!i_tel_tx_fetch |=> $stable(o_tel_tx_sample)) else $error("tel moved");
  sticky_keep_a:
    assert property (!(i_apb.psel && i_apb.pwrite) |=>
      (o_req.irq_error & $past(o_req.irq_error)) == $past(o_req.irq_error)) else $error("lost");
  underrun_cause_a:
    assert property ($rose(o_req.irq_error[0]) |-> $past(i_audio_tx_fetch) ||
      $past(i_audio_tx_fetch, 2)) else $error("underrun no fetch");
  overrun_cause_a:
    assert property ($rose(o_req.irq_error[3]) |-> $past(i_tel_rx_valid) ||
      $past(i_tel_rx_valid, 2)) else $error("overrun no sample");
endmodule : cpf_chk
bind cpf_status_flags cpf_chk #(.DW(DW)) cpf_chk_i (.i_clk_sys(i_clk_sys),
  .i_arst_n(i_arst_n), .i_apb(i_apb), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_audio_tx_fetch(i_audio_tx_fetch), .o_audio_tx_sample(o_audio_tx_sample),
  .i_tel_tx_fetch(i_tel_tx_fetch), .o_tel_tx_sample(o_tel_tx_sample),
  .i_audio_rx_valid(i_audio_rx_valid), .i_tel_rx_valid(i_tel_rx_valid), .o_req(o_req));
`default_nettype wire

//--- cpf_link_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpf_link_model
  import cpf_pkg::*;
(
  input wire logic i_clk_sys,
  output logic [1:0] o_fetch,
  output logic [1:0] o_valid,
  output logic [CPF_DW-1:0] o_data
);
  initial begin
    o_fetch = 2'b00;
    o_valid = 2'b00;
    o_data = 16'h0000;
  end
  task fetch(input int t);
    @(posedge i_clk_sys);
    o_fetch[t] <= 1'b1;
    @(posedge i_clk_sys);
    o_fetch[t] <= 1'b0;
  endtask : fetch
  task put(input int t, input logic [CPF_DW-1:0] d);
    @(posedge i_clk_sys);
    o_valid[t] <= 1'b1;
    o_data <= d;
    @(posedge i_clk_sys);
    o_valid[t] <= 1'b0;
    // released line must not keep showing the sample
    o_data <= ~d;
  endtask : put
endmodule : cpf_link_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cpf_pkg::*;
  logic i_clk_sys;
  logic i_arst_n;
  cpf_apb_req_t apb;
  logic pready;
  logic pslverr;
  logic err;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [15:0] atx;
  logic [15:0] ttx;
  logic [15:0] rdat;
  logic [1:0] fetch;
  logic [1:0] valid;
  cpf_req_t req;
  int mismatches = 0;
  int comparisons = 0;
  int cyc = 0;
  cpf_status_flags cpf_status_flags_i (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_apb(apb),
    .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_audio_tx_fetch(fetch[0]),
    .o_audio_tx_sample(atx), .i_tel_tx_fetch(fetch[1]), .o_tel_tx_sample(ttx),
    .i_audio_rx_valid(valid[0]), .i_audio_rx_data(rdat), .i_tel_rx_valid(valid[1]),
    .i_tel_rx_data(rdat), .o_req(req));
  cpf_link_model cpf_link_model_i (.i_clk_sys(i_clk_sys), .o_fetch(fetch), .o_valid(valid),
    .o_data(rdat));
  task complete_run;
    if (mismatches == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task tick;
    @(posedge i_clk_sys);
    #1;
  endtask : tick
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk_sys);
    apb.penable <= 1'b1;
    // look between edges so the registered answer is settled, and take it at that same negedge
    do @(negedge i_clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge i_clk_sys);
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask : xfer
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      complete_run;
    end
  end
  initial begin
    i_arst_n = 1'b0;
    apb = '0;
    repeat (2) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    tick;
    xfer(1'b0, CPF_OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0500);
    xfer(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    xfer(1'b1, CPF_OFS_CTRL, 32'h0000_0001);
    tick;
    chk(32'(req), 32'h0000_0500);
    xfer(1'b1, CPF_OFS_CTRL, 32'h0000_001F);
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 9; i++) begin
        xfer(1'b1, CPF_OFS_DATA_AUDIO + 8'(4 * t), 32'(i + 1));
        tick;
        chk(32'({req.dma[2*t], req.irq_service[2*t]}), 32'({2{i < 4}}));
      end
      xfer(1'b0, CPF_OFS_STATUS, 32'h0000_0000);
      chk(32'(rd[8+2*t]), 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
        cpf_link_model_i.fetch(t);
        tick;
        chk(32'(t ? ttx : atx), 32'(i < 8 ? i + 1 : 8));
        chk(32'(req.irq_error[2*t]), 32'(i == 8));
      end
      xfer(1'b1, CPF_OFS_DATA_AUDIO + 8'(4 * t), 32'h0000_0077);
      cpf_link_model_i.fetch(t);
      tick;
      chk(32'(t ? ttx : atx), 32'h0000_0077);
      xfer(1'b1, CPF_OFS_STATUS, 32'h0000_0000);
      tick;
      chk(32'(req.irq_error[2*t]), 32'h0000_0001);
      xfer(1'b1, CPF_OFS_STATUS, 32'(16 << (2 * t)));
      tick;
      chk(32'(req.irq_error[2*t]), 32'h0000_0000);
      for (int i = 0; i < 9; i++) begin
        cpf_link_model_i.put(t, 16'h00A0 + 16'(i));
        tick;
        chk(32'({req.dma[2*t+1], req.irq_error[2*t+1]}), 32'({i > 2, i == 8}));
      end
      for (int i = 0; i < 8; i++) begin
        xfer(1'b0, CPF_OFS_DATA_AUDIO + 8'(4 * t), 32'h0000_0000);
        chk(rd, 32'h0000_00A0 + 32'(i));
      end
      xfer(1'b0, CPF_OFS_STATUS, 32'h0000_0000);
      chk(32'({rd[9+2*t], rd[1+2*t]}), 32'h0000_0000);
    end
    complete_run;
  end
endmodule : tb_top
`default_nettype wire
